// ---- hdl/gfag_pkg.sv ----
// package: constants and types for the glyph fetch address generator
package gfag_pkg;

  localparam logic [15:0] GFAG_MPTR_ADDR      = 16'hd018;
  localparam logic [7:0]  GFAG_MPTR_RESET     = 8'h15;
  localparam int          GFAG_GLYPH_LSB      = 1;
  localparam int          GFAG_GLYPH_MSB      = 3;
  localparam int          GFAG_SCREEN_LSB     = 4;
  localparam int          GFAG_GLYPH_BYTES    = 8;
  localparam int          GFAG_GLYPH_COUNT    = 256;
  localparam int          GFAG_ROW_BITS       = 3;
  localparam logic [1:0]  GFAG_BANK_RESET     = 2'h3;
  localparam logic [1:0]  GFAG_ROM_WIN        = 2'h1;
  localparam logic [15:0] GFAG_IO_LO          = 16'hd000;
  localparam logic [15:0] GFAG_IO_HI          = 16'hdfff;
  localparam int          GFAG_PORT_ROM_BIT   = 2;
  localparam logic [7:0]  GFAG_PORT_RESET     = 8'hff;
  localparam int          GFAG_ROM_AW         = 12;

  typedef enum logic [1:0] {
    GFAG_SRC_RAM,
    GFAG_SRC_ROM,
    GFAG_SRC_IO
  } gfag_src_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [2:0] row;
  } gfag_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    gfag_src_t   src;
  } gfag_fetch_t;

endpackage : gfag_pkg

// ---- hdl/gfag_rom.sv ----
// character glyph rom: registered read, contents loaded through a write port
module gfag_rom #(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata_next;

  // no pattern file: contents come in over the load port
  always_comb begin
    rdata_next = mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= rdata_next;
  end

endmodule : gfag_rom

// ---- hdl/gfag_addr.sv ----
// glyph address arithmetic: code*8 + set*2048 + row, bank on top
module gfag_addr
  import gfag_pkg::*;
(
  input  wire logic [7:0]  code,
  input  wire logic [2:0]  row,
  input  wire logic [2:0]  glyph_sel,
  input  wire logic [1:0]  bank_bits,
  output logic      [13:0] inbank,
  output logic      [1:0]  bank
);

  always_comb begin
    bank   = ~bank_bits;
    inbank = {glyph_sel, 11'h000}
           + {3'h0, code, 3'h0}
           + {11'h000, row};
  end

endmodule : gfag_addr

// ---- hdl/gfag_top.sv ----
// glyph fetch address generator with character rom shadowing and cpu decode
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - glyph set is 256 glyphs of 8 bytes
// - set starts at one of 8 positions
// - pointer bits 3..1 pick set, bit 0 ignored
// - set offset is field times 2048
// - bank base added to glyph offset
// - rom shadows bank0 1000-1fff, bank2 9000-9fff
// - banks 1 and 3 see only ram
// - shadow for video only, cpu sees ram
// - rom holds eight 512-byte groups, ordered
// - video shadow fetch always goes to rom
// - cpu d000-dfff: io if port bit2, else rom
// - address is code*8 plus set plus bank
// - screen code and color fetched same slot
// - reset selects glyph field 2
// - bank bits 11,10,01,00 give banks 0..3
// - upper pointer nibble is screen base, kept
module gfag_top
  import gfag_pkg::*;
#(
  parameter int ROM_AW = GFAG_ROM_AW
) (
  input  wire logic              clk,
  input  wire logic              srst,
  // register write/read at the documented address
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // bank select bits and processor port
  input  wire logic [1:0]        bank_bits,
  input  wire logic [7:0]        cpu_port,
  // video fetch request: screen code and color in one slot
  input  wire gfag_req_t         vid_req,
  input  wire logic [3:0]        vid_color,
  output gfag_fetch_t            vid_fetch,
  output logic      [3:0]        vid_color_out,
  output logic      [7:0]        vid_rom_data,
  output logic      [3:0]        screen_base,
  // processor access decode
  input  wire logic              cpu_valid,
  input  wire logic [15:0]       cpu_addr,
  output gfag_fetch_t            cpu_route,
  // rom load
  input  wire logic              rom_we,
  input  wire logic [ROM_AW-1:0] rom_waddr,
  input  wire logic [7:0]        rom_wdata
);

  ////////////////////////////////////////////////////////////////////////////
  // memory pointer register
  logic [7:0] mptr_reg, mptr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       mptr_hit;
  logic       wr_hit;
  logic       rd_hit;

  // only one register is mapped here; any other address reads as zero
  assign mptr_hit = (reg_addr == GFAG_MPTR_ADDR);
  assign wr_hit   = reg_we && mptr_hit;
  assign rd_hit   = reg_re && mptr_hit;

  always_comb begin
    mptr_next  = mptr_reg;
    rdata_next = rdata_reg;
    // software writes whole byte; read-modify-write keeps the screen nibble
    if (wr_hit) begin
      mptr_next = reg_wdata;
    end
    if (rd_hit) begin
      rdata_next = mptr_reg;
    end else if (reg_re) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mptr_reg  <= GFAG_MPTR_RESET;
      rdata_reg <= 8'h00;
    end else begin
      mptr_reg  <= mptr_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank bits come from another block's port pins: two-stage sync
  logic [1:0] bank_s1_reg, bank_s1_next;
  logic [1:0] bank_s2_reg, bank_s2_next;
  logic [7:0] port_s1_reg, port_s1_next;
  logic [7:0] port_s2_reg, port_s2_next;

  // first stage may be metastable: only the second stage feeds logic
  always_comb begin
    bank_s1_next = bank_bits;
    bank_s2_next = bank_s1_reg;
    port_s1_next = cpu_port;
    port_s2_next = port_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bank_s1_reg <= GFAG_BANK_RESET;
      bank_s2_reg <= GFAG_BANK_RESET;
      port_s1_reg <= GFAG_PORT_RESET;
      port_s2_reg <= GFAG_PORT_RESET;
    end else begin
      bank_s1_reg <= bank_s1_next;
      bank_s2_reg <= bank_s2_next;
      port_s1_reg <= port_s1_next;
      port_s2_reg <= port_s2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // video glyph address
  logic [2:0]  glyph_sel;
  logic [13:0] inbank;
  logic [1:0]  bank;

  // bit 0 deliberately unused
  assign glyph_sel = mptr_reg[GFAG_GLYPH_MSB:GFAG_GLYPH_LSB];

  gfag_addr u_addr (
    .code      (vid_req.code),
    .row       (vid_req.row),
    .glyph_sel (glyph_sel),
    .bank_bits (bank_s2_reg),
    .inbank    (inbank),
    .bank      (bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shadow window: only banks 0 and 2 carry the rom image for video
  logic      bank_has_rom;
  logic      in_rom_win;
  gfag_src_t vid_src;

  always_comb begin
    case (bank_s2_reg)
      2'h3:    bank_has_rom = 1'b1;
      2'h1:    bank_has_rom = 1'b1;
      2'h2:    bank_has_rom = 1'b0;
      2'h0:    bank_has_rom = 1'b0;
      default: bank_has_rom = 1'b0;
    endcase
  end

  assign in_rom_win = (inbank[13:12] == GFAG_ROM_WIN);

  // video side only: the processor decode below never looks at this
  always_comb begin
    if (bank_has_rom && in_rom_win) begin
      vid_src = GFAG_SRC_ROM;
    end else begin
      vid_src = GFAG_SRC_RAM;
    end
  end

  gfag_fetch_t vfetch_reg, vfetch_next;
  logic [3:0]  vcolor_reg, vcolor_next;
  logic [ROM_AW-1:0] rom_raddr;

  always_comb begin
    vfetch_next       = vfetch_reg;
    vcolor_next       = vcolor_reg;
    vfetch_next.valid = vid_req.valid;
    if (vid_req.valid) begin
      vfetch_next.addr = {bank, inbank};
      vcolor_next      = vid_color;
      vfetch_next.src  = vid_src;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vfetch_reg <= '{valid: 1'b0, addr: 16'h0000, src: GFAG_SRC_RAM};
      vcolor_reg <= 4'h0;
    end else begin
      vfetch_reg <= vfetch_next;
      vcolor_reg <= vcolor_next;
    end
  end

  // rom offset: low 12 bits of in-bank address cover eight 512-byte groups
  assign rom_raddr = inbank[ROM_AW-1:0];

  gfag_rom #(.AW(ROM_AW)) u_rom (
    .clk   (clk),
    .we    (rom_we),
    .waddr (rom_waddr),
    .wdata (rom_wdata),
    .raddr (rom_raddr),
    .rdata (vid_rom_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // processor decode: shadow never applies here
  gfag_fetch_t croute_reg, croute_next;
  logic        cpu_in_io;
  logic        io_visible;

  // the window flips between io and rom; ram under it is never shadowed
  assign cpu_in_io  = (cpu_addr >= GFAG_IO_LO) && (cpu_addr <= GFAG_IO_HI);
  assign io_visible = port_s2_reg[GFAG_PORT_ROM_BIT];

  always_comb begin
    croute_next       = croute_reg;
    croute_next.valid = cpu_valid;
    if (cpu_valid) begin
      croute_next.addr = cpu_addr;
      if (cpu_in_io) begin
        croute_next.src = io_visible ? GFAG_SRC_IO : GFAG_SRC_ROM;
      end else begin
        croute_next.src = GFAG_SRC_RAM;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      croute_reg <= '{valid: 1'b0, addr: 16'h0000, src: GFAG_SRC_RAM};
    end else begin
      croute_reg <= croute_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic [3:0] sbase_reg, sbase_next;

  always_comb begin
    sbase_next = mptr_reg[7:GFAG_SCREEN_LSB];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sbase_reg <= GFAG_MPTR_RESET[7:GFAG_SCREEN_LSB];
    end else begin
      sbase_reg <= sbase_next;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign vid_fetch     = vfetch_reg;
  assign vid_color_out = vcolor_reg;
  assign cpu_route     = croute_reg;
  assign screen_base   = sbase_reg;

endmodule : gfag_top

// ---- dv/gfag_top_props.sv ----
// checker: fetch timing, address and decode relations at the top ports
module gfag_top_props
  import gfag_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  bank_bits,
  input wire logic [7:0]  cpu_port,
  input wire gfag_req_t   vid_req,
  input wire logic [3:0]  vid_color,
  input wire gfag_fetch_t vid_fetch,
  input wire logic [3:0]  vid_color_out,
  input wire logic        cpu_valid,
  input wire logic [15:0] cpu_addr,
  input wire gfag_fetch_t cpu_route
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mp_reg;
  logic [1:0]  age_reg;
  logic [13:0] ib;
  assign ib = {mp_reg[3:1], 11'h0} + {3'h0, vid_req.code, 3'h0} + {11'h0, vid_req.row};
  // pins pass a synchroniser, so only settled pins are judged
  always_ff @(posedge clk) begin
    if (srst) begin
      mp_reg  <= GFAG_MPTR_RESET;
      age_reg <= 2'h0;
    end else begin
      if (reg_we && reg_addr == GFAG_MPTR_ADDR) begin
        mp_reg <= reg_wdata;
      end
      if (age_reg != 2'h3) begin
        age_reg <= age_reg + 2'h1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_settled;
    age_reg == 2'h3 && $stable(bank_bits) && $stable(cpu_port) &&
    bank_bits == $past(bank_bits, 3) && cpu_port == $past(cpu_port, 3) &&
    bank_bits == $past(bank_bits, 2) && cpu_port == $past(cpu_port, 2);
  endsequence
  chk_fetch_pulse: assert property (vid_req.valid |=> vid_fetch.valid)
    else $error("fetch valid missing");
  chk_no_spurious: assert property (!vid_req.valid |=> !vid_fetch.valid)
    else $error("spurious fetch valid");
  chk_color_slot: assert property (vid_req.valid |=> vid_color_out == $past(vid_color))
    else $error("color not from same slot");
  chk_glyph_addr: assert property (vid_req.valid |=>
    vid_fetch.addr[13:0] == $past(ib)) else $error("in-bank glyph address wrong");
  chk_bank_base: assert property (s_settled ##0 vid_req.valid |=>
    vid_fetch.addr[15:14] == ~$past(bank_bits)) else $error("bank base wrong");
  chk_rom_shadow: assert property (vid_fetch.valid |-> vid_fetch.src ==
    ((!vid_fetch.addr[14] && vid_fetch.addr[13:12] == 2'h1) ? GFAG_SRC_ROM : GFAG_SRC_RAM))
    else $error("shadow source wrong");
  chk_cpu_route: assert property (cpu_valid |=>
    cpu_route.valid && cpu_route.addr == $past(cpu_addr)) else $error("cpu route missing");
  chk_cpu_decode: assert property (s_settled ##0 cpu_valid |=> cpu_route.src ==
    (cpu_route.addr[15:12] != 4'hd ? GFAG_SRC_RAM : $past(cpu_port[2]) ? GFAG_SRC_IO :
    GFAG_SRC_ROM)) else $error("cpu decode wrong");
  chk_reg_read: assert property (reg_re && reg_addr == GFAG_MPTR_ADDR |=>
    reg_rdata == $past(mp_reg)) else $error("pointer readback wrong");
endmodule : gfag_top_props
bind gfag_top gfag_top_props u_gfag_top_props (.clk, .srst, .reg_we, .reg_re, .reg_addr,
  .reg_wdata, .reg_rdata, .bank_bits, .cpu_port, .vid_req, .vid_color, .vid_fetch,
  .vid_color_out, .cpu_valid, .cpu_addr, .cpu_route);

// ---- dv/gfag_mem_model.sv ----
// far-side model: fills the glyph rom with a known byte pattern
module gfag_mem_model (
  input  wire logic        clk,
  input  wire logic        start,
  output logic             rom_we,
  output logic      [11:0] rom_waddr,
  output logic      [7:0]  rom_wdata,
  output logic             done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rom_we    = 1'b0;
    rom_waddr = 12'h000;
    rom_wdata = 8'h00;
    done      = 1'b0;
    @(posedge start);
    // all eight 512-byte groups, each byte is the low address byte xor address bits 11..8
    for (int i = 0; i < 4096; i++) begin
      @(negedge clk);
      rom_we    = 1'b1;
      rom_waddr = 12'(i);
      rom_wdata = 8'(i) ^ 8'(i >> 8);
    end
    @(negedge clk);
    rom_we = 1'b0;
    done   = 1'b1;
  end
endmodule : gfag_mem_model

// ---- dv/gfag_top_tb.sv ----
// testbench: pointer register, glyph fetch addresses and cpu decode
module gfag_top_tb
  import gfag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, srst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, cpu_valid = 1'b0;
  logic [15:0] reg_addr = 16'h0, cpu_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h0, reg_rdata, cpu_port = 8'hff, rom_wdata, d;
  logic [1:0]  bank_bits = 2'h3;
  logic [3:0]  vid_color = 4'h0, vid_color_out, screen_base;
  logic [11:0] rom_waddr;
  logic        rom_we, start = 1'b0, done;
  logic [13:0] ib;
  gfag_req_t   vid_req = '0;
  gfag_fetch_t vid_fetch, cpu_route;
  logic [7:0]  vid_rom_data;
  int          miscompares = 0, checked = 0;
  always #50 clk = ~clk;
  gfag_top u_gfag_top (.clk, .srst, .reg_we, .reg_re, .reg_addr, .reg_wdata, .reg_rdata,
    .bank_bits, .cpu_port, .vid_req, .vid_color, .vid_fetch, .vid_color_out, .vid_rom_data,
    .screen_base, .cpu_valid, .cpu_addr, .cpu_route, .rom_we, .rom_waddr, .rom_wdata);
  gfag_mem_model u_gfag_mem_model (.clk, .start, .rom_we, .rom_waddr, .rom_wdata, .done);
  task automatic cmp(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic reg_op(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_we = w;
    reg_re = !w;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_we = 1'b0;
    reg_re = 1'b0;
    d = reg_rdata;
  endtask : reg_op
  task automatic t_regs();
    reg_op(1'b0, GFAG_MPTR_ADDR, 8'h0);
    cmp("mptr reset", 16'(d), 16'h15);
    cmp("screen base reset", 16'(screen_base), 16'h1);
    reg_op(1'b1, GFAG_MPTR_ADDR, 8'h9d);
    reg_op(1'b1, 16'hd019, 8'hff);
    reg_op(1'b0, GFAG_MPTR_ADDR, 8'h0);
    cmp("mptr readback", 16'(d), 16'h9d);
    cmp("screen base", 16'(screen_base), 16'h9);
  endtask : t_regs
  // every bank with every glyph field; bit 0 toggled to show it is ignored
  task automatic t_vid();
    for (int b = 0; b < 4; b++) begin
      for (int f = 0; f < 8; f++) begin
        @(negedge clk);
        bank_bits = 2'(b);
        reg_op(1'b1, GFAG_MPTR_ADDR, {4'h1, 3'(f), 1'(b)});
        @(negedge clk);
        vid_req = {1'b1, 8'hff - 8'(f * 36), 3'(7 - f)};
        vid_color = 4'(f + b);
        ib = 14'(f * 2048) + 14'((255 - f * 36) * 8) + 14'(7 - f);
        @(negedge clk);
        vid_req.valid = 1'b0;
        cmp("fetch addr", vid_fetch.addr, {~2'(b), ib});
        cmp("fetch valid", 16'(vid_fetch.valid), 16'h1);
        cmp("color", 16'(vid_color_out), 16'(f + b));
        d = (b[0] && ib[13:12] == 2'h1) ? 8'h1 : 8'h0;
        cmp("fetch src", 16'(vid_fetch.src), 16'(d));
        if (d[0]) begin
          cmp("rom byte", 16'(vid_rom_data), 16'(ib[7:0] ^ {4'h0, ib[11:8]}));
        end
      end
    end
  endtask : t_vid
  task automatic t_cpu();
    logic [15:0] ca [6] = '{16'h9000, 16'h1000, 16'hcfff, 16'hd000, 16'hdfff, 16'he000};
    logic [15:0] e;
    for (int p = 0; p < 2; p++) begin
      @(negedge clk);
      // no timer interrupt runs here, so nothing can fire while io is out
      cpu_port = p ? 8'hfb : 8'hff;
      repeat (3) @(negedge clk);
      foreach (ca[i]) begin
        cpu_valid = 1'b1;
        cpu_addr = ca[i];
        @(negedge clk);
        cpu_valid = 1'b0;
        e = (ca[i][15:12] != 4'hd) ? 16'h0 : p ? 16'h1 : 16'h2;
        cmp("cpu src", 16'(cpu_route.src), e);
        cmp("cpu addr", cpu_route.addr, ca[i]);
        @(negedge clk);
      end
    end
    // io window restored before anything else runs
    cpu_port = 8'hff;
    repeat (3) @(negedge clk);
  endtask : t_cpu
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    start = 1'b1;
    for (int i = 0; i < 5000 && !done; i++) begin
      @(negedge clk);
    end
    if (!done) begin
      miscompares++;
      wrap_up();
    end
    t_regs();
    t_vid();
    t_cpu();
    wrap_up();
  end
endmodule : gfag_top_tb
